// file: rtl/aicr_regs.sv
// Input-selection and configuration-one registers driving the analog front end
`default_nettype none

module aicr_regs (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Register access from the serial host logic
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // Input switch matrix controls
  output aicr_pkg::aicr_sel_t input_select_field_o,
  output logic route_normal_o,
  output logic route_inverted_o,
  output logic short_to_mid_o,
  output logic short_to_positive_o,
  output logic external_inputs_connected_o,
  // Front-end configuration
  output logic pos_input_precharge_en_o,
  output logic neg_input_precharge_en_o,
  output logic ref_precharge_en_o,
  output logic common_mode_output_en_o,
  output logic input_range_sel_o,
  output logic reference_range_sel_o
);
  import aicr_pkg::*;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Shared by the write and read paths so the two can never disagree on the map
  function automatic logic is_input_selection(input logic [7:0] addr);
    is_input_selection = (addr == AICR_ADDR_INPUT_SELECTION);
  endfunction

  function automatic logic is_configuration_one(input logic [7:0] addr);
    is_configuration_one = (addr == AICR_ADDR_CONFIGURATION_ONE);
  endfunction

  // Reserved positions are dropped here, so they can never read back as one
  function automatic logic [7:0] keep_writable(input logic [7:0] data, input logic [7:0] mask);
    keep_writable = data & mask;
  endfunction

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0] input_selection_r;
  logic [7:0] configuration_one_r;
  logic [7:0] input_selection_nxt;
  logic [7:0] configuration_one_nxt;
  aicr_sel_t sel_nxt;
  logic sel_wr_en;
  logic cfg_wr_en;

  always_comb
  begin
    sel_wr_en = reg_wr_i && is_input_selection(reg_addr_i);
    cfg_wr_en = reg_wr_i && is_configuration_one(reg_addr_i);
  end

  always_comb
  begin
    input_selection_nxt = input_selection_r;
    configuration_one_nxt = configuration_one_r;
    if (sel_wr_en)
    begin
      input_selection_nxt = keep_writable(reg_wdata_i, AICR_MASK_INPUT_SELECTION);
    end
    else if (cfg_wr_en)
    begin
      configuration_one_nxt = keep_writable(reg_wdata_i, AICR_MASK_CONFIGURATION_ONE);
    end
    sel_nxt = aicr_sel_t'(input_selection_nxt[AICR_SEL_MSB:AICR_SEL_LSB]);
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      input_selection_r <= AICR_RESET_INPUT_SELECTION;
      configuration_one_r <= AICR_RESET_CONFIGURATION_ONE;
    end
    else
    begin
      input_selection_r <= input_selection_nxt;
      configuration_one_r <= configuration_one_nxt;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // Unmapped addresses read zero rather than holding the previous value
  logic [7:0] rdata_nxt;

  always_comb
  begin
    rdata_nxt = 8'h00;
    if (!reg_rd_i)
    begin
      rdata_nxt = 8'h00;
    end
    else if (is_input_selection(reg_addr_i))
    begin
      rdata_nxt = input_selection_r;
    end
    else if (is_configuration_one(reg_addr_i))
    begin
      rdata_nxt = configuration_one_r;
    end
    else
    begin
      rdata_nxt = 8'h00;
    end
  end

  // Read data stands only in the cycle after the strobe; between reads it sits at zero
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      reg_rdata_o <= 8'h00;
    end
    else
    begin
      reg_rdata_o <= rdata_nxt;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      reg_rvalid_o <= 1'b0;
    end
    else
    begin
      reg_rvalid_o <= reg_rd_i;
    end
  end

  // ----------------------------------------
  // Switch matrix decode
  // ----------------------------------------
  // Decoded from the next value so the strobes change in the same edge as the field
  logic route_normal_nxt;
  logic route_inverted_nxt;
  logic short_to_mid_nxt;
  logic short_to_positive_nxt;
  logic external_inputs_connected_nxt;

  always_comb
  begin
    route_normal_nxt = 1'b0;
    route_inverted_nxt = 1'b0;
    short_to_mid_nxt = 1'b0;
    short_to_positive_nxt = 1'b0;
    external_inputs_connected_nxt = 1'b1;
    case (sel_nxt)
      AICR_SEL_NORMAL: route_normal_nxt = 1'b1;
      AICR_SEL_INVERTED: route_inverted_nxt = 1'b1;
      AICR_SEL_SHORT_MID:
      begin
        short_to_mid_nxt = 1'b1;
        external_inputs_connected_nxt = 1'b0;
      end
      // Positive pin stays on the converter, so the external inputs count as connected
      AICR_SEL_SHORT_POS: short_to_positive_nxt = 1'b1;
      default: route_normal_nxt = 1'b1;
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      input_select_field_o <= AICR_SEL_NORMAL;
      route_normal_o <= 1'b1;
      route_inverted_o <= 1'b0;
      short_to_mid_o <= 1'b0;
      short_to_positive_o <= 1'b0;
      external_inputs_connected_o <= 1'b1;
    end
    else
    begin
      input_select_field_o <= sel_nxt;
      route_normal_o <= route_normal_nxt;
      route_inverted_o <= route_inverted_nxt;
      short_to_mid_o <= short_to_mid_nxt;
      short_to_positive_o <= short_to_positive_nxt;
      external_inputs_connected_o <= external_inputs_connected_nxt;
    end
  end

  // ----------------------------------------
  // Front-end enables
  // ----------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      pos_input_precharge_en_o <= 1'b0;
      neg_input_precharge_en_o <= 1'b0;
      ref_precharge_en_o <= 1'b0;
      common_mode_output_en_o <= 1'b0;
      input_range_sel_o <= 1'b0;
      reference_range_sel_o <= 1'b0;
    end
    else
    begin
      pos_input_precharge_en_o <= configuration_one_nxt[AICR_BIT_POS_PRECHARGE];
      neg_input_precharge_en_o <= configuration_one_nxt[AICR_BIT_NEG_PRECHARGE];
      ref_precharge_en_o <= configuration_one_nxt[AICR_BIT_REF_PRECHARGE];
      common_mode_output_en_o <= configuration_one_nxt[AICR_BIT_COMMON_MODE];
      input_range_sel_o <= configuration_one_nxt[AICR_BIT_INPUT_RANGE];
      reference_range_sel_o <= configuration_one_nxt[AICR_BIT_REFERENCE_RANGE];
    end
  end

endmodule

`default_nettype wire

// file: rtl/aicr_pkg.sv
// Constants for the input-selection and configuration-one register slice
`default_nettype none

package aicr_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] AICR_ADDR_INPUT_SELECTION = 8'h04;
  localparam logic [7:0] AICR_ADDR_CONFIGURATION_ONE = 8'h05;
  localparam logic [7:0] AICR_RESET_INPUT_SELECTION = 8'h00;
  localparam logic [7:0] AICR_RESET_CONFIGURATION_ONE = 8'h00;

  // Writable bits; everything else is reserved
  localparam logic [7:0] AICR_MASK_INPUT_SELECTION = 8'h03;
  localparam logic [7:0] AICR_MASK_CONFIGURATION_ONE = 8'h7b;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int AICR_SEL_LSB = 0;
  localparam int AICR_SEL_MSB = 1;
  localparam int AICR_BIT_NEG_PRECHARGE = 0;
  localparam int AICR_BIT_POS_PRECHARGE = 1;
  localparam int AICR_BIT_REF_PRECHARGE = 3;
  localparam int AICR_BIT_COMMON_MODE = 4;
  localparam int AICR_BIT_INPUT_RANGE = 5;
  localparam int AICR_BIT_REFERENCE_RANGE = 6;

  // ----------------------------------------
  // Input-select encodings
  // ----------------------------------------
  typedef enum logic [1:0] {
    AICR_SEL_NORMAL = 2'b00,
    AICR_SEL_INVERTED = 2'b01,
    AICR_SEL_SHORT_MID = 2'b10,
    AICR_SEL_SHORT_POS = 2'b11
  } aicr_sel_t;

endpackage

`default_nettype wire

// file: test/aicr_regs_asserts.sv
// Checker for the input-selection and configuration-one registers
`default_nettype none
module aicr_regs_asserts (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire aicr_pkg::aicr_sel_t input_select_field_o,
  input wire logic route_normal_o,
  input wire logic route_inverted_o,
  input wire logic short_to_mid_o,
  input wire logic short_to_positive_o,
  input wire logic external_inputs_connected_o,
  input wire logic pos_input_precharge_en_o,
  input wire logic neg_input_precharge_en_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic sw;
  logic cw;
  assign sw = reg_wr_i && reg_addr_i == 8'h04;
  assign cw = reg_wr_i && reg_addr_i == 8'h05;
  property p_sel; sw |=> input_select_field_o == $past(reg_wdata_i[1:0]); endproperty
  a_sel: assert property (p_sel) else $error("field not written");
  property p_dec; route_normal_o == (input_select_field_o == 2'b00) && route_inverted_o == (input_select_field_o == 2'b01); endproperty
  a_dec: assert property (p_dec) else $error("polarity decode wrong");
  property p_mid; short_to_mid_o == (input_select_field_o == 2'b10) && external_inputs_connected_o == !short_to_mid_o; endproperty
  a_mid: assert property (p_mid) else $error("mid short wrong");
  property p_pos; short_to_positive_o == (input_select_field_o == 2'b11); endproperty
  a_pos: assert property (p_pos) else $error("positive short wrong");
  property p_pbuf; cw |=> pos_input_precharge_en_o == $past(reg_wdata_i[1]); endproperty
  a_pbuf: assert property (p_pbuf) else $error("pos buffer wrong");
  property p_nbuf; cw |=> neg_input_precharge_en_o == $past(reg_wdata_i[0]); endproperty
  a_nbuf: assert property (p_nbuf) else $error("neg buffer wrong");
  property p_rsv; reg_rd_i && reg_addr_i == 8'h04 |=> reg_rvalid_o && reg_rdata_o[7:2] == 6'h00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits read set");
  property p_rsv_cfg; reg_rd_i && reg_addr_i == 8'h05 |=> reg_rvalid_o && !reg_rdata_o[7] && !reg_rdata_o[2]; endproperty
  a_rsv_cfg: assert property (p_rsv_cfg) else $error("config reserved bits read set");
  c_inv: cover property (route_inverted_o);
  c_mid: cover property (short_to_mid_o);
  c_pos: cover property (short_to_positive_o);
  c_buf: cover property (pos_input_precharge_en_o && neg_input_precharge_en_o);
endmodule
bind aicr_regs aicr_regs_asserts u_chk (
  .core_clk_i(core_clk_i),
  .rst_i(rst_i),
  .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i),
  .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o),
  .reg_rvalid_o(reg_rvalid_o),
  .input_select_field_o(input_select_field_o),
  .route_normal_o(route_normal_o),
  .route_inverted_o(route_inverted_o),
  .short_to_mid_o(short_to_mid_o),
  .short_to_positive_o(short_to_positive_o),
  .external_inputs_connected_o(external_inputs_connected_o),
  .pos_input_precharge_en_o(pos_input_precharge_en_o),
  .neg_input_precharge_en_o(neg_input_precharge_en_o)
);
`default_nettype wire

// file: test/aicr_regs_tb.sv
// Self-checking bench for the register slice
`default_nettype none
module aicr_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import aicr_pkg::*;
  logic core_clk_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, reg_rvalid_o, route_normal_o, route_inverted_o;
  logic short_to_mid_o, short_to_positive_o, external_inputs_connected_o, pos_input_precharge_en_o;
  logic neg_input_precharge_en_o, ref_precharge_en_o, common_mode_output_en_o, input_range_sel_o;
  logic reference_range_sel_o;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
  aicr_sel_t input_select_field_o;
  int mismatches = 0, num_checks = 0, sel_m = 0, cfg_m = 0;
  int exp_q[$];
  aicr_regs uut (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o),
    .input_select_field_o(input_select_field_o),
    .route_normal_o(route_normal_o),
    .route_inverted_o(route_inverted_o),
    .short_to_mid_o(short_to_mid_o),
    .short_to_positive_o(short_to_positive_o),
    .external_inputs_connected_o(external_inputs_connected_o),
    .pos_input_precharge_en_o(pos_input_precharge_en_o),
    .neg_input_precharge_en_o(neg_input_precharge_en_o),
    .ref_precharge_en_o(ref_precharge_en_o),
    .common_mode_output_en_o(common_mode_output_en_o),
    .input_range_sel_o(input_range_sel_o),
    .reference_range_sel_o(reference_range_sel_o)
  );
  initial forever #5 core_clk_i = ~core_clk_i;
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chkall;
    chk(input_select_field_o, sel_m[1:0]);
    chk({route_normal_o, route_inverted_o, short_to_mid_o, short_to_positive_o, external_inputs_connected_o},
        {sel_m == 0, sel_m == 1, sel_m == 2, sel_m == 3, sel_m != 2});
    chk({reference_range_sel_o, input_range_sel_o, common_mode_output_en_o, ref_precharge_en_o, 1'b0,
        pos_input_precharge_en_o, neg_input_precharge_en_o}, cfg_m[6:0]);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    reg_wr_i = 1;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(negedge core_clk_i);
    reg_wr_i = 0;
    if (a == 8'h04) sel_m = d & 8'h03;
    if (a == 8'h05) cfg_m = d & 8'h7b;
    chkall();
    chk(reg_rvalid_o, 8'h00);
    chk(reg_rdata_o, 8'h00);
  endtask
  task automatic rd(input logic [7:0] a, input int e);
    @(negedge core_clk_i);
    reg_rd_i = 1;
    reg_addr_i = a;
    exp_q.push_back(e);
    @(negedge core_clk_i);
    reg_rd_i = 0;
    chk(reg_rvalid_o, 8'h01);
    chk(reg_rdata_o, 8'(exp_q.pop_front()));
  endtask
  initial
  begin
    #200us mismatches++;
    give_verdict();
  end
  initial
  begin
    void'($urandom(772));
    repeat (12) @(negedge core_clk_i);
    rst_i = 0;
    chkall();
    rd(8'h04, 0);
    for (int k = 0; k < 4; k++)
    begin
      wr(8'h04, 8'(($urandom & 8'hfc) | k));
      rd(8'h04, sel_m);
    end
    for (int k = 0; k < 8; k++)
    begin
      wr(8'h05, 8'($urandom));
      rd(8'h05, cfg_m);
    end
    wr(8'h05, 8'hff);
    rd(8'h05, 8'h7b);
    wr(8'h07, 8'($urandom));
    rd(8'h07, 0);
    @(negedge core_clk_i);
    rst_i = 1;
    @(negedge core_clk_i);
    rst_i = 0;
    sel_m = 0;
    cfg_m = 0;
    chkall();
    give_verdict();
  end
endmodule
`default_nettype wire
